//--- bench/serial_host_model.sv
/*
 * Serial host model: start, stop, byte and register access tasks.
 * Assumes the bench resolves the data line with a pull-up into sda_line.
 */
`timescale 1ns/100ps
module serial_host_model (
	input  wire logic clk_sys,
	input  wire logic sda_line,
	output      logic scl,
	output      logic sda_drv
);
	import led_cfg_pkg::*;

	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Data moves only well after scl falls, never near a high phase
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		tick(6);
		scl = 1'b1;
		tick(6);
		r = sda_line;
		scl = 1'b0;
		tick(4);
	endtask

	task automatic start_cond;
		sda_drv = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(6);
		sda_drv = 1'b0;
		tick(6);
		scl = 1'b0;
		tick(4);
	endtask

	task automatic stop_cond;
		sda_drv = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(6);
		sda_drv = 1'b1;
		tick(6);
	endtask

	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(ack_in, ack_n);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// address, direction, register
	task automatic access(input logic [6:0] dev, input logic rd, input logic [7:0] ofs, input logic [7:0] wd,
		output logic [7:0] rdat, output logic ok);
		logic [7:0] q;
		logic       a0;
		logic       a1;
		logic       a2;
		logic       a3;
		start_cond();
		xfer({dev, 1'b0}, 1'b1, q, a0);
		xfer(ofs, 1'b1, q, a1);
		if (rd) begin
			start_cond();
			xfer({dev, 1'b1}, 1'b1, q, a2);
			// Single byte, so the host declines more
			xfer(8'hFF, 1'b1, rdat, a3);
		end else begin
			xfer(wd, 1'b1, q, a2);
			rdat = 8'h00;
		end
		stop_cond();
		ok = !(a0 | a1 | a2);
	endtask

	// Two data bytes in one transfer; the pointer steps between them
	task automatic burst(input logic rd, input logic [7:0] ofs, input logic [15:0] wd,
		output logic [15:0] rdat, output logic ok);
		logic [7:0] q;
		logic       a0;
		logic       a1;
		logic       a2;
		logic       a3;
		start_cond();
		xfer({DEV_ADDR, 1'b0}, 1'b1, q, a0);
		xfer(ofs, 1'b1, q, a1);
		if (rd) begin
			start_cond();
			xfer({DEV_ADDR, 1'b1}, 1'b1, q, a2);
			// Host acks the first byte, declines the second
			xfer(8'hFF, 1'b0, rdat[15:8], q[0]);
			xfer(8'hFF, 1'b1, rdat[7:0], q[0]);
			a3 = 1'b0;
		end else begin
			xfer(wd[15:8], 1'b1, q, a2);
			xfer(wd[7:0], 1'b1, q, a3);
			rdat = 16'h0000;
		end
		stop_cond();
		ok = !(a0 | a1 | a2 | a3);
	endtask
endmodule // serial_host_model

//--- bench/tb.sv
/*
 * Self-checking bench for the configuration and fault register set.
 * Assumes the serial host model and a pulled-up open-drain data line.
 */
`timescale 1ns/100ps
module tb;
	import led_cfg_pkg::*;

	// Arbitrary identity for this bench
	localparam logic [7:0] ID_VAL = 8'hA6;
	localparam int         TMO    = 60000;

	logic       clk_sys = 1'b0;
	logic       srst;
	logic       scl;
	logic       sda_drv;
	logic       sda_line;
	logic       sda_out;
	logic       sda_oe_n;
	logic [5:0] fault_event;
	logic       osc_fl;
	logic       sync;
	logic       thr_fl;
	logic       phase;
	logic [1:0] thr;
	logic [1:0] rate;
	logic [2:0] cnt;
	logic [5:0] sink_en;
	logic       resv;
	logic       ase;
	logic       sat;
	logic       rfr;
	logic       rfs;
	logic       tfr;
	int         n_errors = 0;
	int         checked = 0;
	int         cycles = 0;

	always #20 clk_sys = ~clk_sys;
	assign sda_line = sda_drv & (sda_oe_n | sda_out);

	serial_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

	led_driver_config_fault_regs #(.IDENT_VALUE(ID_VAL)) dut (
		.clk_sys(clk_sys), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .fault_event(fault_event), .osc_pin_floating(osc_fl),
		.sync_clock_present(sync), .threshold_pin_floating(thr_fl), .phase_offset_enable(phase),
		.short_threshold_select(thr), .switch_rate_select(rate), .active_channel_count(cnt),
		.sink_enable(sink_en), .channel_code_reserved(resv), .all_string_short_protect_enable(ase),
		.saturation_time_select(sat), .rate_from_register(rfr), .rate_from_sync(rfs),
		.threshold_from_register(tfr));

	////////////////////////////////////////////////////////////////////////////
	task automatic results;
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic [7:0] q;
		logic       ok;
		host.access(DEV_ADDR, 1'b0, ofs, d, q, ok);
		chk({7'h00, ok}, 8'h01);
	endtask

	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] q;
		logic       ok;
		host.access(DEV_ADDR, 1'b1, ofs, 8'h00, q, ok);
		chk({7'h00, ok}, 8'h01);
		chk(q, exp);
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == TMO) begin
			n_errors++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] v;
		logic [7:0] q;
		logic       ok;
		logic [15:0] w;
		srst = 1'b1;
		fault_event = 6'h00;
		osc_fl = 1'b1;
		sync = 1'b0;
		thr_fl = 1'b1;
		repeat (12) @(negedge clk_sys);
		srst = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk({phase, thr, rate, cnt}, CTRL_RESET);
		chk({2'h0, sink_en}, 8'h3F);
		chk({6'h00, ase, sat}, 8'h00);
		rd(OFS_CTRL, CTRL_RESET);
		rd(OFS_PROT, 8'h00);
		rd(OFS_IDENT, ID_VAL);
		rd(8'h00, READ_UNMAPPED);
		rd(8'h07, READ_UNMAPPED);
		// sinks untied here, phase offset allowed
		for (int c = 0; c < 8; c++) begin
			v = {c[0], c[1:0], ~c[1:0], c[2:0]};
			wr(OFS_CTRL, v);
			chk({phase, thr, rate, cnt}, v);
			chk({2'h0, sink_en}, (c > 5) ? 8'h00 : (8'h3F >> c));
			chk({7'h00, resv}, (c > 5) ? 8'h01 : 8'h00);
			rd(OFS_CTRL, v);
		end
		for (int p = 0; p < 8; p++) begin
			{osc_fl, sync, thr_fl} = p[2:0];
			repeat (6) @(negedge clk_sys);
			chk({5'h00, rfr, rfs, tfr}, {5'h00, p[2] & ~p[1], p[1], p[0]});
		end
		wr(OFS_PROT, 8'hFF);
		chk({6'h00, ase, sat}, 8'h03);
		rd(OFS_PROT, 8'hC0);
		wr(OFS_PROT, 8'h40);
		chk({6'h00, ase, sat}, 8'h01);
		wr(OFS_IDENT, 8'h00);
		rd(OFS_IDENT, ID_VAL);
		host.access(7'h39, 1'b0, OFS_PROT, 8'h80, q, ok);
		chk({7'h00, ok}, 8'h00);
		rd(OFS_PROT, 8'h40);
		for (int i = 0; i < 6; i++) begin
			fault_event[i] = 1'b1;
			repeat (8) @(negedge clk_sys);
			fault_event[i] = 1'b0;
			repeat (8) @(negedge clk_sys);
			rd(OFS_PROT, 8'h40 | (8'h01 << i));
			rd(OFS_PROT, 8'h40);
		end
		// Fault still present at clear time relatches
		fault_event[5] = 1'b1;
		repeat (8) @(negedge clk_sys);
		rd(OFS_PROT, 8'h60);
		fault_event[5] = 1'b0;
		rd(OFS_PROT, 8'h60);
		rd(OFS_PROT, 8'h40);
		host.burst(1'b0, OFS_CTRL, 16'hA980, w, ok);
		chk({7'h00, ok}, 8'h01);
		chk({phase, thr, rate, cnt}, 8'hA9);
		chk({6'h00, ase, sat}, 8'h02);
		host.burst(1'b1, OFS_CTRL, 16'h0000, w, ok);
		chk({7'h00, ok}, 8'h01);
		chk(w[15:8], 8'hA9);
		chk(w[7:0], 8'h80);
		fault_event[2] = 1'b1;
		repeat (8) @(negedge clk_sys);
		fault_event[2] = 1'b0;
		srst = 1'b1;
		repeat (4) @(negedge clk_sys);
		srst = 1'b0;
		repeat (6) @(negedge clk_sys);
		rd(OFS_CTRL, CTRL_RESET);
		rd(OFS_PROT, 8'h00);
		results();
	end
endmodule // tb

//--- verilog/led_cfg_pkg.sv
/*
 * Constants for the backlight driver configuration and fault register set:
 * serial address, register offsets, field positions and reset values.
 * Assumes a single system clock; no timing constants are needed here.
 */
package led_cfg_pkg;
	localparam logic [6:0] DEV_ADDR       = 7'h38;
	localparam logic [7:0] OFS_CTRL       = 8'h01;
	localparam logic [7:0] OFS_PROT       = 8'h02;
	localparam logic [7:0] OFS_IDENT      = 8'h03;
	localparam logic [7:0] READ_UNMAPPED  = 8'h00;
	// Arbitrary neutral value
	localparam logic [7:0] IDENT_DEFAULT  = 8'h5A;

	localparam int         NUM_SINKS      = 6;
	localparam int         FLAG_COUNT     = 6;
	localparam int         BIT_PHASE      = 7;
	localparam int         THR_LSB        = 5;
	localparam int         RATE_LSB       = 3;
	localparam int         CHAN_LSB       = 0;
	localparam int         BIT_STR_SHORT  = 7;
	localparam int         BIT_SAT_TIME   = 6;
	localparam logic [2:0] CHAN_CODE_MAX  = 3'h5;

	// Control reset: phase 0, threshold 01, rate 01, channels 000
	localparam logic [7:0] CTRL_RESET     = 8'h28;
	localparam logic [1:0] PROT_RESET     = 2'h0;
	localparam logic [5:0] FLAGS_RESET    = 6'h00;
	localparam int         BYTE_BITS      = 8;
endpackage

//--- verilog/led_driver_config_fault_regs.sv
/*
 * Configuration, protection control, sticky fault flags and identity register
 * of a six-string backlight boost driver, reached over the serial target.
 * Assumes fault events and pin-strap sense inputs are asynchronous levels.
 */
`timescale 1ns/100ps
module led_driver_config_fault_regs #(
	parameter logic [7:0] IDENT_VALUE = led_cfg_pkg::IDENT_DEFAULT
) (
	input  wire logic                                  clk_sys,
	input  wire logic                                  srst,
	input  wire logic                                  scl_in,
	input  wire logic                                  sda_in,
	output      logic                                  sda_out,
	output      logic                                  sda_oe_n,
	input  wire logic [led_cfg_pkg::FLAG_COUNT-1:0]    fault_event,
	input  wire logic                                  osc_pin_floating,
	input  wire logic                                  sync_clock_present,
	input  wire logic                                  threshold_pin_floating,
	output      logic                                  phase_offset_enable,
	output      logic [1:0]                            short_threshold_select,
	output      logic [1:0]                            switch_rate_select,
	output      logic [2:0]                            active_channel_count,
	output      logic [led_cfg_pkg::NUM_SINKS-1:0]     sink_enable,
	output      logic                                  channel_code_reserved,
	output      logic                                  all_string_short_protect_enable,
	output      logic                                  saturation_time_select,
	output      logic                                  rate_from_register,
	output      logic                                  rate_from_sync,
	output      logic                                  threshold_from_register
);
	import led_cfg_pkg::*;

	logic [7:0]            reg_addr, wr_data, rd_data;
	logic                  wr_strobe, rd_strobe;
	logic [7:0]            ctrl_q;
	logic [1:0]            prot_q;
	logic [FLAG_COUNT-1:0] flag_q, flag_d, event_s, read_clear;
	logic [FLAG_COUNT-1:0] event_m_q, event_q;
	logic [2:0]            pin_m_q, pin_q;
	logic [NUM_SINKS-1:0]  sink_d;

	serial_target u_target (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.sda_out   (sda_out),
		.sda_oe_n  (sda_oe_n),
		.reg_addr  (reg_addr),
		.wr_strobe (wr_strobe),
		.wr_data   (wr_data),
		.rd_strobe (rd_strobe),
		.rd_data   (rd_data)
	);

	////////////////////////////////////////////////////////////////
	// Writable registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_strobe && reg_addr == OFS_CTRL) begin
			ctrl_q <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prot_q <= PROT_RESET;
		// flag bits of the write dropped
		end else if (wr_strobe && reg_addr == OFS_PROT) begin
			prot_q <= {wr_data[BIT_STR_SHORT], wr_data[BIT_SAT_TIME]};
		end
	end

	////////////////////////////////////////////////////////////////
	// Read mux
	always_comb begin
		case (reg_addr)
			OFS_CTRL:  rd_data = ctrl_q;
			OFS_PROT:  rd_data = {prot_q, flag_q};
			OFS_IDENT: rd_data = IDENT_VALUE;
			default:   rd_data = READ_UNMAPPED;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Sticky fault flags
	always_ff @(posedge clk_sys) begin
		event_m_q <= fault_event;
		event_q   <= event_m_q;
		pin_m_q   <= {osc_pin_floating, sync_clock_present, threshold_pin_floating};
		pin_q     <= pin_m_q;
	end

	assign event_s = event_q;

	// Clear the flags held in the strobe cycle, one cycle after the read byte was loaded, so a flag set in that cycle is cleared unseen
	assign read_clear = (rd_strobe && reg_addr == OFS_PROT) ? flag_q : FLAGS_RESET;

	genvar gi;
	generate
		for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
			assign flag_d[gi] = event_s[gi] | (flag_q[gi] & ~read_clear[gi]);
		end
		for (gi = 0; gi < NUM_SINKS; gi++) begin : g_sink
			assign sink_d[gi] = (ctrl_q[CHAN_LSB +: 3] <= CHAN_CODE_MAX)
				&& ((gi + int'(ctrl_q[CHAN_LSB +: 3])) < NUM_SINKS);
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (srst)
			flag_q <= FLAGS_RESET;
		else
			flag_q <= flag_d;
	end

	////////////////////////////////////////////////////////////////
	// Registered control outputs
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			phase_offset_enable             <= CTRL_RESET[BIT_PHASE];
			short_threshold_select          <= CTRL_RESET[THR_LSB +: 2];
			switch_rate_select              <= CTRL_RESET[RATE_LSB +: 2];
			active_channel_count            <= CTRL_RESET[CHAN_LSB +: 3];
			sink_enable                     <= '0;
			channel_code_reserved           <= 1'b0;
			all_string_short_protect_enable <= PROT_RESET[1];
			saturation_time_select          <= PROT_RESET[0];
			rate_from_register              <= 1'b0;
			rate_from_sync                  <= 1'b0;
			threshold_from_register         <= 1'b0;
		end else begin
			phase_offset_enable             <= ctrl_q[BIT_PHASE];
			short_threshold_select          <= ctrl_q[THR_LSB +: 2];
			switch_rate_select              <= ctrl_q[RATE_LSB +: 2];
			active_channel_count            <= ctrl_q[CHAN_LSB +: 3];
			// reserved codes turn all sinks off
			sink_enable                     <= sink_d;
			channel_code_reserved           <= ctrl_q[CHAN_LSB +: 3] > CHAN_CODE_MAX;
			all_string_short_protect_enable <= prot_q[1];
			saturation_time_select          <= prot_q[0];
			rate_from_sync                  <= pin_q[1];
			rate_from_register              <= pin_q[2] & ~pin_q[1];
			threshold_from_register         <= pin_q[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	sequence s_ctrl_write;
		wr_strobe && reg_addr == OFS_CTRL;
	endsequence

	sequence s_flag_read;
		rd_strobe && reg_addr == OFS_PROT;
	endsequence

	AST_PHASE_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
		s_ctrl_write |-> ##2 phase_offset_enable == $past(wr_data[BIT_PHASE], 2))
		else $error("Phase offset enable did not follow write");

	AST_THRESHOLD_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
		s_ctrl_write |-> ##2 short_threshold_select == $past(wr_data[6:5], 2))
		else $error("Threshold select did not follow write");

	AST_RATE_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
		s_ctrl_write |-> ##2 switch_rate_select == $past(wr_data[4:3], 2))
		else $error("Rate select did not follow write");

	AST_SINKS_ALL: assert property (@(posedge clk_sys) disable iff (srst)
		(s_ctrl_write ##0 (wr_data[2:0] == 3'h0)) |-> ##2 sink_enable == 6'h3F)
		else $error("Code zero must enable all six sinks");

	AST_SINKS_ONE: assert property (@(posedge clk_sys) disable iff (srst)
		(s_ctrl_write ##0 (wr_data[2:0] == 3'h5)) |-> ##2 sink_enable == 6'h01)
		else $error("Code five must leave only the first sink");

	AST_RATE_SOURCE: assert property (@(posedge clk_sys) disable iff (srst)
		!(rate_from_register && rate_from_sync))
		else $error("Two switching rate sources at once");

	AST_PROT_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
		(wr_strobe && reg_addr == OFS_PROT) |-> ##2
			(all_string_short_protect_enable == $past(wr_data[7], 2)
			&& saturation_time_select == $past(wr_data[6], 2)))
		else $error("Protection controls did not follow write");

	AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(event_m_q[0]) |-> ##2 flag_q[0])
		else $error("Fault event did not set its flag");

	AST_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
		(flag_q[1] && !(rd_strobe && reg_addr == OFS_PROT)) |=> flag_q[1])
		else $error("Fault flag dropped without a read");

	AST_FLAG_READ_CLEAR: assert property (@(posedge clk_sys) disable iff (srst)
		(s_flag_read ##0 (flag_q[2] && !event_s[2])) |=> !flag_q[2])
		else $error("Read did not clear fault flag");

	AST_IDENT_READ: assert property (@(posedge clk_sys) disable iff (srst)
		(reg_addr == OFS_IDENT) |-> rd_data == IDENT_VALUE)
		else $error("Identity byte wrong");

	AST_RO_FLAGS: assert property (@(posedge clk_sys) disable iff (srst)
		(wr_strobe && event_s == '0 && !rd_strobe) |=> $stable(flag_q))
		else $error("Write altered read-only flags");
endmodule // led_driver_config_fault_regs

//--- verilog/serial_target.sv
/*
 * Byte-level serial target: start/stop detection, address match, register
 * pointer with auto-increment, write strobe and read load strobe.
 * Assumes scl/sda are asynchronous pins; sda is open drain (three signals).
 */
`timescale 1ns/100ps
module serial_target (
	input  wire logic                         clk_sys,
	input  wire logic                         srst,
	input  wire logic                         scl_in,
	input  wire logic                         sda_in,
	output      logic                         sda_out,
	output      logic                         sda_oe_n,
	output      logic [7:0]                   reg_addr,
	output      logic                         wr_strobe,
	output      logic [7:0]                   wr_data,
	output      logic                         rd_strobe,
	input  wire logic [7:0]                   rd_data
);
	import led_cfg_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
	} tgt_state_e;

	tgt_state_e state_q;
	logic [1:0] scl_m_q, sda_m_q;
	logic       scl_q, sda_q, scl_p_q, sda_p_q;
	logic [7:0] shift_q, tx_q;
	logic [3:0] cnt_q;
	logic       dir_read_q, master_ack_q, drive_low_q;
	logic       rise, fall, start_c, stop_c;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection
	always_ff @(posedge clk_sys) begin
		scl_m_q <= {scl_m_q[0], scl_in};
		sda_m_q <= {sda_m_q[0], sda_in};
		scl_q   <= scl_m_q[1];
		sda_q   <= sda_m_q[1];
		scl_p_q <= scl_q;
		sda_p_q <= sda_q;
	end

	assign rise    = scl_q & ~scl_p_q;
	assign fall    = ~scl_q & scl_p_q;
	assign start_c = scl_q & scl_p_q & sda_p_q & ~sda_q;
	assign stop_c  = scl_q & scl_p_q & ~sda_p_q & sda_q;

	assign sda_out  = 1'b0;
	assign sda_oe_n = ~drive_low_q;

	////////////////////////////////////////////////////////////////
	// Byte sequencer
	always_ff @(posedge clk_sys) begin
		wr_strobe <= 1'b0;
		rd_strobe <= 1'b0;
		if (srst) begin
			state_q      <= ST_IDLE;
			shift_q      <= 8'h00;
			tx_q         <= 8'h00;
			cnt_q        <= 4'h0;
			dir_read_q   <= 1'b0;
			master_ack_q <= 1'b0;
			drive_low_q  <= 1'b0;
			reg_addr     <= 8'h00;
			wr_data      <= 8'h00;
		end else if (start_c) begin
			state_q     <= ST_ADDR;
			cnt_q       <= 4'h0;
			drive_low_q <= 1'b0;
		end else if (stop_c) begin
			state_q     <= ST_IDLE;
			drive_low_q <= 1'b0;
		end else begin
			if (rise) begin
				if (state_q == ST_ADDR || state_q == ST_REG || state_q == ST_WDATA) begin
					shift_q <= {shift_q[6:0], sda_q};
					cnt_q   <= cnt_q + 4'h1;
				end
				if (state_q == ST_RACK)
					master_ack_q <= ~sda_q;
			end
			if (fall) begin
				case (state_q)
					ST_ADDR: if (cnt_q == 4'(BYTE_BITS)) begin
						cnt_q <= 4'h0;
						if (shift_q[7:1] == DEV_ADDR) begin
							dir_read_q  <= shift_q[0];
							drive_low_q <= 1'b1;
							state_q     <= ST_ADDR_ACK;
						end else begin
							state_q <= ST_IDLE;
						end
					end
					ST_REG: if (cnt_q == 4'(BYTE_BITS)) begin
						cnt_q       <= 4'h0;
						reg_addr    <= shift_q;
						drive_low_q <= 1'b1;
						state_q     <= ST_REG_ACK;
					end
					ST_WDATA: if (cnt_q == 4'(BYTE_BITS)) begin
						cnt_q       <= 4'h0;
						wr_data     <= shift_q;
						wr_strobe   <= 1'b1;
						drive_low_q <= 1'b1;
						state_q     <= ST_WDATA_ACK;
					end
					ST_ADDR_ACK, ST_RACK: begin
						if (state_q == ST_ADDR_ACK && !dir_read_q) begin
							drive_low_q <= 1'b0;
							state_q     <= ST_REG;
						end else if (state_q == ST_RACK && !master_ack_q) begin
							drive_low_q <= 1'b0;
							state_q     <= ST_IDLE;
						end else begin
							tx_q        <= rd_data;
							rd_strobe   <= 1'b1;
							drive_low_q <= ~rd_data[7];
							cnt_q       <= 4'h1;
							state_q     <= ST_RDATA;
						end
					end
					ST_REG_ACK: begin
						drive_low_q <= 1'b0;
						state_q     <= ST_WDATA;
					end
					ST_WDATA_ACK: begin
						drive_low_q <= 1'b0;
						reg_addr    <= reg_addr + 8'h01;
						state_q     <= ST_WDATA;
					end
					ST_RDATA: begin
						if (cnt_q == 4'(BYTE_BITS)) begin
							drive_low_q <= 1'b0;
							reg_addr    <= reg_addr + 8'h01;
							state_q     <= ST_RACK;
						end else begin
							tx_q        <= {tx_q[6:0], 1'b0};
							drive_low_q <= ~tx_q[6];
							cnt_q       <= cnt_q + 4'h1;
						end
					end
					default: state_q <= state_q;
				endcase
			end
		end
	end

	AST_ADDR_ACK_MATCH: assert property (@(posedge clk_sys) disable iff (srst)
		(state_q == ST_ADDR && fall && cnt_q == 4'(BYTE_BITS) && shift_q[7:1] != DEV_ADDR)
			|=> (state_q == ST_IDLE && !drive_low_q))
		else $error("Foreign address was acknowledged");
endmodule // serial_target
